// ### rtl/channel_cfg_calibration_regs.sv
// Behaviour
// R1: Config at word 22h resets zero; offsets 23h/24h, gain low 26h reset zero.
// R2: Config bits 15:6 hold a ten-bit signed phase delay, read/write.
// R3: Config bit 2 disables DC block for this channel; zero follows global.
// R4: Config bits 1:0 select pins, shorted, positive or negative test.
// R5: Config bits 5:3 and calibration low bytes 7:0 read as zero.
// R6: Offset bits 23:8 live in all of the offset high register at 23h.
// R7: Offset bits 7:0 live in bits 15:8 of offset low register at 24h.
// R8: Gain is 24-bit unsigned, from zero to just under two.
// R9: Gain bits 23:8 live in the fully writable gain high register.
// R10: Gain high sits at 25h and resets to 8000h, unity gain.
// R11: Gain bits 7:0 live in bits 15:8 of gain low register at 26h.
// R12: Previous channel gain bits 7:0 at 21h bits 15:8, reset zero.
// R13: Writes to reserved bits are ignored; they always read zero.
//
// Added by the designer: the AXI4-Lite slave port.
module channel_cfg_calibration_regs #(
  parameter int ADDR_W = 12
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address.
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Channel settings toward the filter datapath.
  output logic signed [9:0] phase_delay,
  output logic dc_block_disable,
  output logic [1:0] input_select,
  output logic signed [23:0] offset_cal,
  output logic [23:0] gain_cal,
  output logic [7:0] prev_gain_cal_lower
);

  // ----------------------------------------------------------------------
  // Address helpers.
  // ----------------------------------------------------------------------

  // Byte address of a register index; aligned word only. An address that
  // is not a multiple of four never matches, so a misaligned access is
  // refused like an unmapped one instead of aliasing onto a register.
  function automatic logic hits(input logic [ADDR_W-1:0] a,
                                input logic [7:0] idx);
    hits = (a[ADDR_W-1:2] == (ADDR_W-2)'(idx)) && (a[1:0] == 2'b00);
  endfunction : hits

  // ----------------------------------------------------------------------
  // Write path.
  // ----------------------------------------------------------------------
  // Captured write, its response registers and the commit strobes.
  logic wr_both;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic wr_go;
  logic wr_done;

  // Address and data may arrive in either order; each is held until the
  // response has been taken.
  axil_wr_capture #(.ADDR_W(ADDR_W)) u_wr_capture (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .done(wr_done),
    .both(wr_both),
    .addr(wr_addr),
    .data(wr_data),
    .strb(wr_strb)
  );

  // A write commits once, in the cycle the response is raised. Holding the
  // captured address and data until the response handshake means a slow
  // master cannot make the same write land twice.
  assign wr_go = wr_both && !bvalid_reg;
  assign wr_done = bvalid_reg && s_axi_bready;

  // Per-register write enables; unmapped addresses write nothing. Each
  // select line matches one aligned word, so no write touches two words.
  logic [5:0] wr_sel;
  assign wr_sel[0] = wr_go && hits(wr_addr, chan_cal_pkg::IDX_PREV_GAIN_LOW);
  assign wr_sel[1] = wr_go && hits(wr_addr, chan_cal_pkg::IDX_CONFIG);
  assign wr_sel[2] = wr_go && hits(wr_addr, chan_cal_pkg::IDX_OFFSET_HIGH);
  assign wr_sel[3] = wr_go && hits(wr_addr, chan_cal_pkg::IDX_OFFSET_LOW);
  assign wr_sel[4] = wr_go && hits(wr_addr, chan_cal_pkg::IDX_GAIN_HIGH);
  assign wr_sel[5] = wr_go && hits(wr_addr, chan_cal_pkg::IDX_GAIN_LOW);

  // A write that selects no register is refused with a slave error.
  logic wr_mapped;
  assign wr_mapped = |wr_sel;                         // [R13]

  // ----------------------------------------------------------------------
  // Register storage.
  // ----------------------------------------------------------------------
  // Reset value of each register, in address order from 21h to 26h.
  localparam logic [15:0] RST_V [6] = '{
    chan_cal_pkg::RST_ZERO, chan_cal_pkg::RST_ZERO,   // [R1] [R12]
    chan_cal_pkg::RST_ZERO, chan_cal_pkg::RST_ZERO,   // [R1]
    chan_cal_pkg::RST_GAIN_HIGH,                      // [R10]
    chan_cal_pkg::RST_ZERO                            // [R1]
  };
  // Reserved bits are never writable, so they can never read non-zero.
  localparam logic [15:0] MASK_V [6] = '{
    chan_cal_pkg::LOW_WMASK,                          // [R12] [R13]
    chan_cal_pkg::CONFIG_WMASK,                       // [R5] [R13]
    chan_cal_pkg::FULL_WMASK,                         // [R6]
    chan_cal_pkg::LOW_WMASK,                          // [R7] [R5]
    chan_cal_pkg::FULL_WMASK,                         // [R9]
    chan_cal_pkg::LOW_WMASK                           // [R11] [R5]
  };

  // Stored words, in the same order as the reset and mask tables.
  logic [15:0] reg_val [6];

  // One instance per register, each with its own reset and write mask.
  // Building every register from one cell keeps the reserved-bit handling
  // in a single place: a bit outside the mask is never written.
  for (genvar i = 0; i < 6; i++) begin : g_regs
    cal_reg16 #(
      .RESET_VALUE(RST_V[i]),
      .WRITE_MASK(MASK_V[i])
    ) u_reg (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_en(wr_sel[i]),
      .wr_data(wr_data[15:0]),
      .wr_strb(wr_strb[1:0]),
      .value(reg_val[i])
    );
  end

  // ----------------------------------------------------------------------
  // Write response.
  // ----------------------------------------------------------------------

  // Unmapped addresses answer with a slave error and change no storage.
  // The response is a register, so it stands unchanged until the master
  // takes it, whatever the capture stage does meanwhile.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= chan_cal_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? chan_cal_pkg::RESP_OKAY
                             : chan_cal_pkg::RESP_SLVERR;
    end else if (wr_done) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Response outputs come straight from their flops.
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // ----------------------------------------------------------------------
  // Read path.
  // ----------------------------------------------------------------------
  // Read answer registers and the read decode.
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic rd_take;
  logic [15:0] rd_word;
  logic rd_hit;

  // One read at a time; a new address is taken only when idle. The ready
  // output is its own flop, the inverse of the answer's valid, so the bus
  // never sees a combinational path through the design's outputs.
  assign s_axi_arready = arready_reg;
  assign rd_take = s_axi_arvalid && arready_reg;

  // Read decode, one select line per register in storage order. Reserved
  // bits need no masking here: they come straight from storage that can
  // never hold anything but zero there.
  logic [5:0] rd_sel;
  assign rd_sel[0] = hits(s_axi_araddr, chan_cal_pkg::IDX_PREV_GAIN_LOW);
  assign rd_sel[1] = hits(s_axi_araddr, chan_cal_pkg::IDX_CONFIG);
  assign rd_sel[2] = hits(s_axi_araddr, chan_cal_pkg::IDX_OFFSET_HIGH);
  assign rd_sel[3] = hits(s_axi_araddr, chan_cal_pkg::IDX_OFFSET_LOW);
  assign rd_sel[4] = hits(s_axi_araddr, chan_cal_pkg::IDX_GAIN_HIGH);
  assign rd_sel[5] = hits(s_axi_araddr, chan_cal_pkg::IDX_GAIN_LOW);
  assign rd_hit = |rd_sel;                            // [R13]
  assign rd_word = rd_sel[0] ? reg_val[0] :
                   rd_sel[1] ? reg_val[1] :
                   rd_sel[2] ? reg_val[2] :
                   rd_sel[3] ? reg_val[3] :
                   rd_sel[4] ? reg_val[4] :
                   rd_sel[5] ? reg_val[5] :
                   16'h0000;                          // [R5] [R13]

  // Read data is registered and held until the master accepts it. Storage
  // is sampled at the edge that takes the address, so a write landing
  // later does not change an answer already on offer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= chan_cal_pkg::RESP_OKAY;
    end else if (rd_take) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= {16'h0000, rd_word};
      rresp_reg <= rd_hit ? chan_cal_pkg::RESP_OKAY
                          : chan_cal_pkg::RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  // Read outputs come straight from their flops.
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ----------------------------------------------------------------------
  // Field extraction.
  // ----------------------------------------------------------------------
  logic [9:0] phase_field;
  logic dcblk_field;
  logic [1:0] select_field;
  logic [23:0] offset_field;
  logic [23:0] gain_field;
  logic [7:0] prev_gain_field;

  // Named slices of the stored words. The calibration values are split
  // across a high register and the top byte of a low register, so the
  // low register's reserved byte never reaches the datapath.
  assign phase_field = reg_val[1][chan_cal_pkg::PHASE_MSB:
                                  chan_cal_pkg::PHASE_LSB];      // [R2]
  assign dcblk_field = reg_val[1][chan_cal_pkg::DCBLK_BIT];      // [R3]
  assign select_field = reg_val[1][chan_cal_pkg::SEL_MSB:
                                   chan_cal_pkg::SEL_LSB];       // [R4]
  assign offset_field = {reg_val[2],
                         reg_val[3][chan_cal_pkg::LOWBYTE_MSB:
                                    chan_cal_pkg::LOWBYTE_LSB]}; // [R6] [R7]
  assign gain_field = {reg_val[4],
                       reg_val[5][chan_cal_pkg::LOWBYTE_MSB:
                                  chan_cal_pkg::LOWBYTE_LSB]};   // [R8] [R11]
  assign prev_gain_field = reg_val[0][chan_cal_pkg::LOWBYTE_MSB:
                                      chan_cal_pkg::LOWBYTE_LSB]; // [R12]

  // ----------------------------------------------------------------------
  // Settings outputs, registered so they change one cycle after a write.
  // ----------------------------------------------------------------------

  // The extra flop stage keeps every output straight from a register, at
  // the cost of one cycle between a write landing and the datapath seeing
  // it; software cannot observe that cycle over the bus.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_delay <= 10'sh000;
      dc_block_disable <= 1'b0;
      input_select <= chan_cal_pkg::SEL_PINS;
      offset_cal <= 24'sh000000;
      gain_cal <= {chan_cal_pkg::RST_GAIN_HIGH, 8'h00};
      prev_gain_cal_lower <= 8'h00;
    end else begin
      phase_delay <= phase_field;                        // [R2]
      dc_block_disable <= dcblk_field;                   // [R3]
      input_select <= select_field;                      // [R4]
      offset_cal <= offset_field;                        // [R6] [R7]
      gain_cal <= gain_field;                            // [R8] [R11]
      prev_gain_cal_lower <= prev_gain_field;            // [R12]
    end
  end

  // Protection bits carry no meaning for this bank. The upper data half
  // and its strobes are dropped as well, because every register is only
  // sixteen bits wide and sits in the low half of its word.
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot, wr_data[31:16],
                         wr_strb[3:2]};

endmodule : channel_cfg_calibration_regs

// ### rtl/chan_cal_pkg.sv
package chan_cal_pkg;

  // ----------------------------------------------------------------------
  // Register indices (word addresses); byte address is four times these.
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_PREV_GAIN_LOW = 8'h21;
  localparam logic [7:0] IDX_CONFIG = 8'h22;
  localparam logic [7:0] IDX_OFFSET_HIGH = 8'h23;
  localparam logic [7:0] IDX_OFFSET_LOW = 8'h24;
  localparam logic [7:0] IDX_GAIN_HIGH = 8'h25;
  localparam logic [7:0] IDX_GAIN_LOW = 8'h26;

  // ----------------------------------------------------------------------
  // Field layouts and reset values.
  // ----------------------------------------------------------------------
  localparam int PHASE_MSB = 15;
  localparam int PHASE_LSB = 6;
  localparam int DCBLK_BIT = 2;
  localparam int SEL_MSB = 1;
  localparam int SEL_LSB = 0;
  localparam int LOWBYTE_MSB = 15;
  localparam int LOWBYTE_LSB = 8;
  localparam logic [15:0] CONFIG_WMASK = 16'hFFC7;
  localparam logic [15:0] LOW_WMASK = 16'hFF00;
  localparam logic [15:0] FULL_WMASK = 16'hFFFF;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_GAIN_HIGH = 16'h8000;

  // Input select codes.
  typedef enum logic [1:0] {
    SEL_PINS = 2'b00,
    SEL_SHORTED = 2'b01,
    SEL_TEST_POS = 2'b10,
    SEL_TEST_NEG = 2'b11
  } input_select_t;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : chan_cal_pkg

// ### rtl/cal_reg16.sv
// ------------------------------------------------------------------------
// One 16-bit register with a writable-bit mask and a reset value.
// ------------------------------------------------------------------------
module cal_reg16 #(
  parameter logic [15:0] RESET_VALUE = 16'h0000,
  parameter logic [15:0] WRITE_MASK = 16'hFFFF
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Write port.
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] wr_strb,
  // Stored value.
  output logic [15:0] value
);

  logic [15:0] lane_mask;
  logic [15:0] value_next;

  // Only writable bits in enabled lanes change; masked bits stay zero.
  assign lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}} & WRITE_MASK;
  assign value_next = (value & ~lane_mask) | (wr_data & lane_mask);

  // Register update.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value <= RESET_VALUE;
    end else if (wr_en) begin
      value <= value_next;
    end
  end

endmodule : cal_reg16

// ### rtl/axil_wr_capture.sv
// ------------------------------------------------------------------------
// Captures write address and write data in either order.
// ------------------------------------------------------------------------
module axil_wr_capture #(
  parameter int ADDR_W = 12
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Address and data channels.
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Completion from the response stage.
  input wire logic done,
  // Captured write.
  output logic both,
  output logic [ADDR_W-1:0] addr,
  output logic [31:0] data,
  output logic [3:0] strb
);

  // Each ready is a flop of its own, so the bus sees register outputs. It
  // drops at the edge that takes its item and returns after the response.
  assign both = !awready && !wready;

  // Hold each half until the response has been accepted.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      addr <= '0;
      data <= 32'h00000000;
      strb <= 4'h0;
    end else if (done) begin
      awready <= 1'b1;
      wready <= 1'b1;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        addr <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        data <= wdata;
        strb <= wstrb;
      end
    end
  end

endmodule : axil_wr_capture

// ### test/channel_cfg_calibration_regs_assertions.sv
module channel_cfg_calibration_regs_chk #(
  parameter int ADDR_W = 12
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Read channels.
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Channel settings.
  input wire logic signed [9:0] phase_delay,
  input wire logic dc_block_disable,
  input wire logic [1:0] input_select,
  input wire logic signed [23:0] offset_cal,
  input wire logic [23:0] gain_cal,
  input wire logic [7:0] prev_gain_cal_lower
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------
  // Read address tracking.
  // ----------
  logic [ADDR_W-1:0] ra_reg;
  wire logic [15:0] rd16 = s_axi_rdata[15:0];
  wire logic rv = s_axi_rvalid;
  wire logic ok = s_axi_rresp == 2'b00;
  wire logic mapped = ra_reg inside {'h84, 'h88, 'h8C, 'h90, 'h94, 'h98};
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Remember the address so each answer can be tied to its register.
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) ra_reg <= s_axi_araddr;
  end

  // ----------
  // Properties.
  // ----------
  property p_rst;
    $rose(aresetn) |-> gain_cal == 24'h800000 && offset_cal == 24'h0;
  endproperty
  a_rst: assert property (p_rst)
    else $error("settings wrong after reset");
  property p_hi;
    s_axi_arvalid && s_axi_arready |=> rv && s_axi_rdata[31:16] == 16'h0;
  endproperty
  a_hi: assert property (p_hi)
    else $error("read answer late or upper half set");
  property p_bad;
    rv && !mapped |-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0;
  endproperty
  a_bad: assert property (p_bad)
    else $error("unmapped read answered wrongly");
  property p_cfg;
    $rose(rv) && ra_reg == 'h88 |->
      ok && rd16 == {phase_delay, 3'b000, dc_block_disable, input_select};
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("config read disagrees with outputs");
  property p_ohi;
    $rose(rv) && ra_reg == 'h8C |-> ok && rd16 == offset_cal[23:8];
  endproperty
  a_ohi: assert property (p_ohi)
    else $error("offset high disagrees");
  property p_olo;
    $rose(rv) && ra_reg == 'h90 |-> ok && rd16 == {offset_cal[7:0], 8'h00};
  endproperty
  a_olo: assert property (p_olo)
    else $error("offset low disagrees");
  property p_ghi;
    $rose(rv) && ra_reg == 'h94 |-> ok && rd16 == gain_cal[23:8];
  endproperty
  a_ghi: assert property (p_ghi)
    else $error("gain high disagrees");
  property p_glo;
    $rose(rv) && ra_reg == 'h98 |-> ok && rd16 == {gain_cal[7:0], 8'h00};
  endproperty
  a_glo: assert property (p_glo)
    else $error("gain low disagrees");
  property p_prev;
    $rose(rv) && ra_reg == 'h84 |-> ok && rd16 == {prev_gain_cal_lower, 8'h00};
  endproperty
  a_prev: assert property (p_prev)
    else $error("previous gain low disagrees");
  c_err: cover property (rv && s_axi_rresp == 2'b10);
  c_neg: cover property (phase_delay < 0);
  c_tst: cover property (input_select == 2'b11);
endmodule : channel_cfg_calibration_regs_chk

bind channel_cfg_calibration_regs channel_cfg_calibration_regs_chk
  #(.ADDR_W(ADDR_W)) chk_inst (.*);

// ### test/channel_cfg_calibration_regs_tb.sv
module channel_cfg_calibration_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------
  // Signals and model state.
  // ----------
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, dc_block_disable;
  logic [1:0] s_axi_bresp, s_axi_rresp, input_select;
  logic signed [9:0] phase_delay;
  logic signed [23:0] offset_cal;
  logic [23:0] gain_cal;
  logic [7:0] prev_gain_cal_lower;
  int n_fail = 0, total_checks = 0;
  logic [15:0] m [6];
  // Writable bits per register; the rest must stay zero.
  localparam logic [15:0] WM [6] = '{16'hFF00, 16'hFFC7, 16'hFFFF,
                                     16'hFF00, 16'hFFFF, 16'hFF00};
  localparam logic [11:0] BAD [4] = '{12'h080, 12'h089, 12'h09C, 12'h000};

  channel_cfg_calibration_regs channel_cfg_calibration_regs_inst (.*);

  // A 40 MHz clock.
  always #12.5 aclk = ~aclk;

  // ----------
  // Tasks.
  // ----------
  task automatic summarize();
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic good, input string s);
    total_checks++;
    if (good !== 1'b1) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, s);
    end
  endtask : chk

  // Index of a register, or -1 when the byte address decodes to nothing.
  function automatic int ix(input logic [11:0] a);
    if (a[1:0] != 2'b00 || a < 12'h084 || a > 12'h098) return -1;
    return int'((a - 12'h084) >> 2);
  endfunction : ix

  task automatic rst();
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    m = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
  endtask : rst

  task automatic outs();
    chk(phase_delay === m[1][15:6], "phase");
    chk({dc_block_disable, input_select} === m[1][2:0], "cfg");
    chk(offset_cal === {m[2], m[3][15:8]}, "offset");
    chk(gain_cal === {m[4], m[5][15:8]}, "gain");
    chk(prev_gain_cal_lower === m[0][15:8], "prev gain");
  endtask : outs

  // Address and data go out together; each drops once taken.
  task automatic wr(input logic [11:0] a, input logic [15:0] d,
                    input logic [1:0] s);
    int i;
    logic [15:0] ln;
    i = ix(a);
    ln = {{8{s[1]}}, {8{s[0]}}};
    if (i >= 0) m[i] = (m[i] & ~(WM[i] & ln)) | (d & WM[i] & ln);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {16'($urandom), d};
    s_axi_wstrb <= {2'($urandom), s};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (40) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp === (i < 0 ? 2'b10 : 2'b00), "bresp");
        return;
      end
    end
    chk(1'b0, "write timeout");
    summarize();
  endtask : wr

  task automatic rd(input logic [11:0] a);
    int i;
    i = ix(a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (40) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata === {16'h0, (i < 0 ? 16'h0 : m[i])}, "rdata");
        chk(s_axi_rresp === (i < 0 ? 2'b10 : 2'b00), "rresp");
        outs();
        return;
      end
    end
    chk(1'b0, "read timeout");
    summarize();
  endtask : rd

  // ----------
  // Main sequence.
  // ----------
  initial begin
    int k;
    logic [11:0] a;
    k = $urandom(32'hAE7FBEC0);
    rst();
    for (k = 0; k < 6; k++) rd(12'h084 + 12'(4 * k));
    // All ones shows which bits hold and which stay zero.
    for (k = 0; k < 6; k++) begin
      wr(12'h084 + 12'(4 * k), 16'hFFFF, 2'b11);
      rd(12'h084 + 12'(4 * k));
    end
    // Every select code, with the block bypass both ways.
    for (k = 0; k < 8; k++) begin
      wr(12'h088, {10'(k * 97), 3'b111, 3'(k)}, 2'b11);
      rd(12'h088);
    end
    foreach (BAD[j]) begin
      wr(BAD[j], 16'($urandom), 2'b11);
      rd(BAD[j]);
    end
    repeat (30) begin
      a = 12'h084 + 12'(4 * ($urandom % 6));
      wr(a, 16'($urandom), 2'($urandom));
      rd(a);
    end
    // A second reset in mid-run must bring back unity gain.
    rst();
    for (k = 0; k < 6; k++) rd(12'h084 + 12'(4 * k));
    summarize();
  end
endmodule : channel_cfg_calibration_regs_tb
